// ===== hdl/eci_pkg.sv
// constants and types for the energy and charge integrator
// Operation
// - power adds each voltage times current sample; dc current adds each current sample
// - in rms mode current adds the per-update current value once per update
// - normal mode with zero timer runs manual: start until stop
// - manual mode stops and holds at ten thousand hours elapsed
// - any mode stops and holds when the energy or charge sum reaches its display limit
// - standard mode stops and holds on timer expiry or stop, whichever first
// - continuous mode clears and restarts on each timer expiry until stop
// - stop freezes values at the previous display update, dropping later samples
// - separate positive and negative energy totals plus their sum, every mode
// - charge split only in dc; otherwise positive is total, negative minus zero
// - display range 99999 counts, 999999 only at mega prefix
// - at 100000 counts the decimal point shifts, dropping one digit
// - negative readings bottom out at minus 99999 at mega prefix
// - external remote start, stop and reset act exactly like the keys
// - continuous mode with zero timer: start raises error, no integration
// - timer accepts zero to ten thousand hours, default zero
// - reset only after stop; returns values and time to pre-start state
`default_nettype none
package eci_pkg;
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned TICK_S        = 1;
   localparam int unsigned SEC_CYCLES    = CLK_HZ * TICK_S;
   localparam int unsigned MAX_HOURS     = 10000;
   localparam int unsigned MAX_SECONDS   = MAX_HOURS * 3600;
   localparam int unsigned TIMER_RST     = 0;
   localparam int unsigned ACC_W         = 64;
   localparam int unsigned SAMP_W        = 16;
   localparam int unsigned TIME_W        = 26;
   localparam logic [3:0]  DEC_MAX       = 4'h6;
   localparam logic [3:0]  DEC_MEGA      = 4'h6;
   localparam logic [23:0] CNT_LIM       = 24'h01869f;  // 99999
   localparam logic [23:0] CNT_LIM_MEGA  = 24'h0f423f;  // 999999
   localparam logic [23:0] CNT_SHIFT     = 24'h0186a0;  // 100000
   // event bit positions
   localparam int unsigned EV_TIMER = 0;
   localparam int unsigned EV_MAXT  = 1;
   localparam int unsigned EV_OVF   = 2;
   localparam int unsigned EV_ERR   = 3;
   localparam int unsigned EV_W     = 4;
   typedef enum logic [2:0] {
      ECI_IDLE = 3'b001,
      ECI_RUN  = 3'b010,
      ECI_STOP = 3'b100
   } eci_state_t;
endpackage
`default_nettype wire

// ===== hdl/eci_scale.sv
// signed accumulator to display count and decimal shift
`default_nettype none
module eci_scale #(
   parameter int unsigned ACC_W = 64
) (
   input  wire logic signed [ACC_W-1:0] acc,
   output logic          [23:0]         count,
   output logic          [3:0]          shift,
   output logic                         at_limit
);
   // the core reads the low 32 bits of every accumulator
   if (ACC_W < 32) begin : g_width_chk
      $error("ACC_W must be at least 32");
   end
   logic [ACC_W-1:0] mag;
   logic [ACC_W-1:0] lim;
   always_comb begin
      mag      = acc[ACC_W-1] ? ACC_W'(-acc) : ACC_W'(acc);
      shift    = 4'h0;
      // divide by ten until under the shift threshold, at most DEC_MAX times
      for (int i = 0; i < int'(eci_pkg::DEC_MAX); i++) begin
         if (mag >= ACC_W'(eci_pkg::CNT_SHIFT)) begin
            mag   = mag / ACC_W'(10);
            shift = shift + 4'h1;
         end
      end
      // extra digit only at mega prefix and only for positive values
      if (shift == eci_pkg::DEC_MEGA && !acc[ACC_W-1])
         lim = ACC_W'(eci_pkg::CNT_LIM_MEGA);
      else
         lim = ACC_W'(eci_pkg::CNT_LIM);
      if (shift == eci_pkg::DEC_MEGA && mag >= lim && !acc[ACC_W-1]) begin
         at_limit = 1'b1;
      end else if (shift == eci_pkg::DEC_MEGA && acc[ACC_W-1] && mag >= lim) begin
         at_limit = 1'b1;
      end else begin
         at_limit = 1'b0;
      end
      count = mag[23:0];
   end
endmodule
`default_nettype wire

// ===== hdl/eci_core.sv
// energy and charge integration controller
`default_nettype none
module eci_core #(
   parameter int unsigned SEC_CYCLES = eci_pkg::SEC_CYCLES
) (
   input  wire logic                                mclk,
   input  wire logic                                rst_n,
   input  wire logic                                ce,
   input  wire logic                                key_start,
   input  wire logic                                key_stop,
   input  wire logic                                key_reset,
   input  wire logic                                ext_start,
   input  wire logic                                ext_stop,
   input  wire logic                                ext_reset,
   input  wire logic                                samp_vld,
   input  wire logic signed [eci_pkg::SAMP_W-1:0]   samp_v,
   input  wire logic signed [eci_pkg::SAMP_W-1:0]   samp_i,
   input  wire logic                                upd_vld,
   input  wire logic signed [eci_pkg::SAMP_W-1:0]   upd_i,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [31:0]                         reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic [31:0]                              reg_rdata,
   output logic                                     irq,
   output logic                                     running,
   output logic [eci_pkg::TIME_W-1:0]               elapsed_s
);
   localparam int unsigned AW = eci_pkg::ACC_W;
   localparam int unsigned TW = eci_pkg::TIME_W;
   // prescaler compares against SEC_CYCLES-1, so one cycle per second cannot work
   if (SEC_CYCLES < 2) begin : g_sec_chk
      $error("SEC_CYCLES too small");
   end

   // --------------------------------------------------------------
   // register offsets
   // --------------------------------------------------------------
   localparam logic [7:0] R_CTRL  = 8'h00;  // bit0 continuous, bit1 dc mode
   localparam logic [7:0] R_TIMER = 8'h04;  // seconds
   localparam logic [7:0] R_STAT  = 8'h08;
   localparam logic [7:0] R_MASK  = 8'h0c;
   localparam logic [7:0] R_TIME  = 8'h10;
   localparam logic [7:0] R_EPOS  = 8'h14;
   localparam logic [7:0] R_ENEG  = 8'h18;
   localparam logic [7:0] R_ESUM  = 8'h1c;
   localparam logic [7:0] R_QPOS  = 8'h20;
   localparam logic [7:0] R_QNEG  = 8'h24;
   localparam logic [7:0] R_QSUM  = 8'h28;
   localparam logic [7:0] R_SCALE = 8'h2c;

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      eci_pkg::eci_state_t      st;
      logic                     cont;
      logic                     dc;
      logic [TW-1:0]            timer;
      logic [TW-1:0]            tsec;
      logic [31:0]              pre;
      logic signed [AW-1:0]     e_pos;
      logic signed [AW-1:0]     e_neg;
      logic signed [AW-1:0]     q_pos;
      logic signed [AW-1:0]     q_neg;
      logic signed [AW-1:0]     e_pos_s;   // snapshot at last display update
      logic signed [AW-1:0]     e_neg_s;
      logic signed [AW-1:0]     q_pos_s;
      logic signed [AW-1:0]     q_neg_s;
      logic [TW-1:0]            tsec_s;
      logic [eci_pkg::EV_W-1:0] stat;
      logic [eci_pkg::EV_W-1:0] mask;
      logic [31:0]              rdata;
   } eci_regs_t;
   eci_regs_t r_r, r_nxt;

   logic                 do_start, do_stop, do_reset;
   logic signed [31:0]   prod;
   logic signed [AW-1:0] e_sum, q_sum, q_neg_view;
   logic [23:0]          cnt_e, cnt_q;
   logic [3:0]           sh_e, sh_q;
   logic                 lim_e, lim_q;
   logic                 sec_tick;

   // keys and remote signal are merged so they behave identically
   assign do_start = key_start | ext_start;
   assign do_stop  = key_stop  | ext_stop;
   assign do_reset = key_reset | ext_reset;
   assign prod     = samp_v * samp_i;
   assign e_sum    = r_r.e_pos + r_r.e_neg;
   assign q_sum    = r_r.q_pos + r_r.q_neg;
   // outside dc the negative charge total shows zero
   assign q_neg_view = r_r.dc ? r_r.q_neg : '0;
   assign sec_tick = (r_r.pre == 32'(SEC_CYCLES - 1));

   // ------------------------------------------------------------------
   // display scaling
   // ------------------------------------------------------------------
   eci_scale #(.ACC_W(AW)) u_scale_e (
      .acc      (e_sum),
      .count    (cnt_e),
      .shift    (sh_e),
      .at_limit (lim_e)
   );
   eci_scale #(.ACC_W(AW)) u_scale_q (
      .acc      (q_sum),
      .count    (cnt_q),
      .shift    (sh_q),
      .at_limit (lim_q)
   );

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [eci_pkg::EV_W-1:0] ev;
      logic                     expire;
      ev     = '0;
      expire = 1'b0;
      r_nxt  = r_r;
      unique case (r_r.st)
         eci_pkg::ECI_IDLE: begin
            if (do_start) begin
               if (r_r.cont && r_r.timer == '0)
                  ev[eci_pkg::EV_ERR] = 1'b1;
               else begin
                  r_nxt.st  = eci_pkg::ECI_RUN;
                  r_nxt.pre = '0;
               end
            end
         end
         eci_pkg::ECI_RUN: begin
            // samples of the current update period are staged
            if (samp_vld) begin
               if (prod >= 0)
                  r_nxt.e_pos = r_r.e_pos + AW'(prod);
               else
                  r_nxt.e_neg = r_r.e_neg + AW'(prod);
               if (r_r.dc) begin
                  if (samp_i >= 0)
                     r_nxt.q_pos = r_r.q_pos + AW'(samp_i);
                  else
                     r_nxt.q_neg = r_r.q_neg + AW'(samp_i);
               end
            end
            if (!r_r.dc && upd_vld)
               r_nxt.q_pos = r_r.q_pos + AW'(upd_i);
            // display update commits a snapshot
            if (upd_vld) begin
               r_nxt.e_pos_s = r_nxt.e_pos;
               r_nxt.e_neg_s = r_nxt.e_neg;
               r_nxt.q_pos_s = r_nxt.q_pos;
               r_nxt.q_neg_s = r_nxt.q_neg;
               r_nxt.tsec_s  = r_r.tsec;
            end
            r_nxt.pre = sec_tick ? '0 : r_r.pre + 32'h1;
            if (sec_tick)
               r_nxt.tsec = r_r.tsec + TW'(1);
            expire = sec_tick && r_r.timer != '0 && (r_r.tsec + TW'(1) >= r_r.timer);
            if (do_stop) begin
               // drop everything since the last display update
               r_nxt.st    = eci_pkg::ECI_STOP;
               r_nxt.e_pos = r_r.e_pos_s;
               r_nxt.e_neg = r_r.e_neg_s;
               r_nxt.q_pos = r_r.q_pos_s;
               r_nxt.q_neg = r_r.q_neg_s;
               r_nxt.tsec  = r_r.tsec_s;
            end else if (lim_e || lim_q) begin
               r_nxt.st = eci_pkg::ECI_STOP;
               ev[eci_pkg::EV_OVF] = 1'b1;
            end else if (r_r.timer == '0 && sec_tick &&
                         r_r.tsec + TW'(1) >= TW'(eci_pkg::MAX_SECONDS)) begin
               r_nxt.st = eci_pkg::ECI_STOP;
               ev[eci_pkg::EV_MAXT] = 1'b1;
            end else if (expire) begin
               ev[eci_pkg::EV_TIMER] = 1'b1;
               if (r_r.cont) begin
                  r_nxt.e_pos = '0;
                  r_nxt.e_neg = '0;
                  r_nxt.q_pos = '0;
                  r_nxt.q_neg = '0;
                  r_nxt.tsec  = '0;
                  r_nxt.e_pos_s = '0;
                  r_nxt.e_neg_s = '0;
                  r_nxt.q_pos_s = '0;
                  r_nxt.q_neg_s = '0;
                  r_nxt.tsec_s  = '0;
               end else
                  r_nxt.st = eci_pkg::ECI_STOP;
            end
         end
         eci_pkg::ECI_STOP: begin
            // reset honoured only once stopped
            if (do_reset) begin
               r_nxt.st    = eci_pkg::ECI_IDLE;
               r_nxt.e_pos = '0;
               r_nxt.e_neg = '0;
               r_nxt.q_pos = '0;
               r_nxt.q_neg = '0;
               r_nxt.tsec  = '0;
               r_nxt.e_pos_s = '0;
               r_nxt.e_neg_s = '0;
               r_nxt.q_pos_s = '0;
               r_nxt.q_neg_s = '0;
               r_nxt.tsec_s  = '0;
            end
         end
         default: r_nxt.st = eci_pkg::ECI_IDLE;
      endcase

      // configuration writes only while idle, not once stopped
      if (reg_wr && r_r.st == eci_pkg::ECI_IDLE) begin
         if (reg_addr == R_CTRL) begin
            r_nxt.cont = reg_wdata[0];
            r_nxt.dc   = reg_wdata[1];
         end
         if (reg_addr == R_TIMER && reg_wdata <= 32'(eci_pkg::MAX_SECONDS))
            r_nxt.timer = TW'(reg_wdata);
      end
      if (reg_wr && reg_addr == R_MASK)
         r_nxt.mask = reg_wdata[eci_pkg::EV_W-1:0];
      // set beats write-one clear
      if (reg_wr && reg_addr == R_STAT)
         r_nxt.stat = (r_r.stat & ~reg_wdata[eci_pkg::EV_W-1:0]) | ev;
      else
         r_nxt.stat = r_r.stat | ev;

      r_nxt.rdata = 32'h0;
      if (reg_rd) begin
         unique case (reg_addr)
            R_CTRL:  r_nxt.rdata = {30'h0, r_r.dc, r_r.cont};
            R_TIMER: r_nxt.rdata = 32'(r_r.timer);
            R_STAT:  r_nxt.rdata = 32'(r_r.stat);
            R_MASK:  r_nxt.rdata = 32'(r_r.mask);
            R_TIME:  r_nxt.rdata = 32'(r_r.tsec);
            R_EPOS:  r_nxt.rdata = r_r.e_pos[31:0];
            R_ENEG:  r_nxt.rdata = r_r.e_neg[31:0];
            R_ESUM:  r_nxt.rdata = e_sum[31:0];
            R_QPOS:  r_nxt.rdata = r_r.dc ? r_r.q_pos[31:0] : q_sum[31:0];
            R_QNEG:  r_nxt.rdata = q_neg_view[31:0];
            R_QSUM:  r_nxt.rdata = q_sum[31:0];
            R_SCALE: r_nxt.rdata = {sh_q, cnt_q[11:0], sh_e, cnt_e[11:0]};
            default: r_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r_r       <= '0;
         r_r.st    <= eci_pkg::ECI_IDLE;
         r_r.timer <= TW'(eci_pkg::TIMER_RST);
      end else if (ce) begin
         r_r <= r_nxt;
      end
   end

   assign reg_rdata = r_r.rdata;
   assign irq       = |(r_r.stat & r_r.mask);
   assign running   = (r_r.st == eci_pkg::ECI_RUN);
   assign elapsed_s = r_r.tsec;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n || !ce);

   sequence s_run_stop;
      running && do_stop;
   endsequence

   err_no_start_a: assert property (
      !running && r_r.st == eci_pkg::ECI_IDLE && do_start && r_r.cont && r_r.timer == '0
      |=> !running && r_r.stat[eci_pkg::EV_ERR])
      else $error("start with zero timer in continuous mode");
   stop_freeze_a: assert property (
      s_run_stop |=> r_r.st == eci_pkg::ECI_STOP && r_r.tsec == $past(r_r.tsec_s))
      else $error("stop did not restore snapshot");
   time_frozen_a: assert property (
      !running |=> $stable(r_r.tsec) || $past(do_reset))
      else $error("elapsed time moved while stopped");
   reset_only_stopped_a: assert property (
      running && do_reset && !do_stop |=> r_r.st != eci_pkg::ECI_IDLE)
      else $error("reset accepted while running");
   ovf_stop_a: assert property (
      running && !do_stop && (lim_e || lim_q)
      |=> !running && r_r.stat[eci_pkg::EV_OVF])
      else $error("overflow did not stop integration");
   std_expire_a: assert property (
      running && !do_stop && !lim_e && !lim_q && !r_r.cont && sec_tick &&
      r_r.timer != '0 && r_r.tsec + TW'(1) >= r_r.timer |=> !running)
      else $error("standard mode did not stop on expiry");
   cont_restart_a: assert property (
      running && !do_stop && !lim_e && !lim_q && r_r.cont && sec_tick &&
      r_r.timer != '0 && r_r.tsec + TW'(1) >= r_r.timer
      |=> running && r_r.tsec == '0)
      else $error("continuous mode did not restart");
   irq_level_a: assert property (
      running && !do_stop && (lim_e || lim_q) && r_r.mask[eci_pkg::EV_OVF] |=> irq)
      else $error("interrupt missing for unmasked status");
   stat_clear_a: assert property (
      reg_wr && reg_addr == R_STAT && !running && !do_start
      |=> (r_r.stat & $past(reg_wdata[eci_pkg::EV_W-1:0])) == '0)
      else $error("status bit not cleared by write of one");
endmodule
`default_nettype wire

// ===== test/eci_front.sv
// sampling front end model: instantaneous samples and display updates
`default_nettype none
module eci_front (
   input  wire logic                          mclk,
   output logic                               samp_vld,
   output logic signed [eci_pkg::SAMP_W-1:0]  samp_v,
   output logic signed [eci_pkg::SAMP_W-1:0]  samp_i,
   output logic                               upd_vld,
   output logic signed [eci_pkg::SAMP_W-1:0]  upd_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      samp_vld = 1'b0;
      upd_vld = 1'b0;
      samp_v = 16'sh5a5a;
      samp_i = 16'sha5a5;
      upd_i = 16'sh3c3c;
   end
   // data lines show the inverse once a strobe is gone, so stale values never look valid
   task automatic send(input logic signed [15:0] v, input logic signed [15:0] i);
      @(posedge mclk);
      samp_vld <= 1'b1;
      samp_v <= v;
      samp_i <= i;
      @(posedge mclk);
      samp_vld <= 1'b0;
      samp_v <= ~v;
      samp_i <= ~i;
   endtask
   // one display update with the per-update rms current
   task automatic update(input logic signed [15:0] i);
      @(posedge mclk);
      upd_vld <= 1'b1;
      upd_i <= i;
      @(posedge mclk);
      upd_vld <= 1'b0;
      upd_i <= ~i;
   endtask
endmodule
`default_nettype wire

// ===== test/energy_charge_integrator_tb_top.sv
// self-checking testbench for the energy and charge integrator
`default_nettype none
module energy_charge_integrator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SEC = 8;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [5:0] cmd = 6'h00;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   wire logic [31:0] reg_rdata;
   wire logic irq;
   wire logic running;
   wire logic [eci_pkg::TIME_W-1:0] elapsed_s;
   wire logic samp_vld;
   wire logic upd_vld;
   wire logic signed [15:0] samp_v;
   wire logic signed [15:0] samp_i;
   wire logic signed [15:0] upd_i;
   int n_mismatch = 0;
   int n_checks = 0;
   // ----------------------------------------------------------------
   // clock, partner and design
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   eci_front eci_front_i (.mclk(mclk), .samp_vld(samp_vld), .samp_v(samp_v),
      .samp_i(samp_i), .upd_vld(upd_vld), .upd_i(upd_i));
   eci_core #(.SEC_CYCLES(SEC)) eci_core_i (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .key_start(cmd[0]), .key_stop(cmd[1]), .key_reset(cmd[2]),
      .ext_start(cmd[3]), .ext_stop(cmd[4]), .ext_reset(cmd[5]),
      .samp_vld(samp_vld), .samp_v(samp_v), .samp_i(samp_i), .upd_vld(upd_vld),
      .upd_i(upd_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .running(running),
      .elapsed_s(elapsed_s));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask
   // one-cycle command pulse: 0 start, 1 stop, 2 reset; add 3 for the remote inputs
   task automatic pulse(input int k);
      @(posedge mclk);
      cmd[k] <= 1'b1;
      @(posedge mclk);
      cmd <= 6'h00;
      #1;
   endtask
   task automatic end_of_test;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_regs;
      rd_chk("timer default", 8'h04, 32'h0);
      rd_chk("status", 8'h08, 32'h0);
      rd_chk("time", 8'h10, 32'h0);
      rd_chk("unmapped", 8'h40, 32'h0);
      wr(8'h04, 32'd36000001);
      rd_chk("timer over max", 8'h04, 32'h0);
      wr(8'h04, 32'd36000000);
      rd_chk("timer at max", 8'h04, 32'd36000000);
   endtask
   // manual dc run: samples after the last update are dropped at stop
   task automatic t_manual_dc;
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h2);
      pulse(0);
      chk("running", 32'h1, {31'h0, running});
      eci_front_i.send(16'sd100, 16'sd3);
      eci_front_i.send(16'sd50, -16'sd2);
      eci_front_i.update(16'sd0);
      eci_front_i.send(16'sd7, 16'sd7);
      pulse(1);
      chk("stopped", 32'h0, {31'h0, running});
      rd_chk("epos", 8'h14, 32'd300);
      rd_chk("eneg", 8'h18, -32'sd100);
      rd_chk("esum", 8'h1c, 32'd200);
      rd_chk("qpos", 8'h20, 32'd3);
      rd_chk("qneg", 8'h24, -32'sd2);
      rd_chk("qsum", 8'h28, 32'd1);
      pulse(5);
      rd_chk("epos after reset", 8'h14, 32'h0);
      rd_chk("time after reset", 8'h10, 32'h0);
   endtask
   // standard mode: timer expiry stops, holds time, flags and interrupts
   task automatic t_standard;
      int n;
      n = 0;
      wr(8'h00, 32'h0);
      wr(8'h04, 32'd3);
      pulse(3);
      pulse(2);
      chk("reset ignored while running", 32'h1, {31'h0, running});
      while (running === 1'b1 && n < 100) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk("run length", 32'(3 * SEC - 2), 32'(n));
      chk("elapsed port", 32'd3, 32'(elapsed_s));
      repeat (2 * SEC) @(posedge mclk);
      rd_chk("time held", 8'h10, 32'd3);
      rd_chk("expiry flag", 8'h08, 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(8'h0c, 32'h1);
      #1;
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(8'h08, 32'h1);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd_chk("flag cleared", 8'h08, 32'h0);
      pulse(2);
      rd_chk("time reset", 8'h10, 32'h0);
   endtask
   // negative energy runs into its display floor: the 94th full-scale sample trips it
   task automatic t_overflow;
      wr(8'h04, 32'h0);
      wr(8'h0c, 32'h4);
      pulse(0);
      repeat (100) eci_front_i.send(16'sh8000, 16'sh7fff);
      #1;
      chk("overflow stop", 32'h0, {31'h0, running});
      rd_chk("eneg held", 8'h18, 32'h802f0000);
      rd_chk("overflow flag", 8'h08, 32'h4);
      chk("irq overflow", 32'h1, {31'h0, irq});
      wr(8'h08, 32'h4);
      pulse(2);
   endtask
   // continuous mode: zero timer is refused, otherwise it restarts each expiry
   task automatic t_continuous;
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h1);
      wr(8'h0c, 32'h8);
      pulse(0);
      chk("no start on zero timer", 32'h0, {31'h0, running});
      rd_chk("error flag", 8'h08, 32'h8);
      chk("irq error", 32'h1, {31'h0, irq});
      wr(8'h08, 32'h8);
      wr(8'h04, 32'd2);
      pulse(0);
      repeat (5 * SEC + 3) @(posedge mclk);
      #1;
      chk("still running", 32'h1, {31'h0, running});
      chk("time restarted", 32'd1, 32'(elapsed_s));
      pulse(4);
      chk("stopped by remote", 32'h0, {31'h0, running});
      pulse(2);
   endtask
   // rms charge: one update value per update, negative total reads zero
   task automatic t_rms;
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      pulse(0);
      @(posedge mclk);
      ce <= 1'b0;
      repeat (2 * SEC) @(posedge mclk);
      ce <= 1'b1;
      #1;
      chk("time frozen by ce", 32'h0, 32'(elapsed_s));
      eci_front_i.send(-16'sd4, 16'sd5);
      eci_front_i.update(16'sd9);
      eci_front_i.update(16'sd9);
      pulse(1);
      rd_chk("rms qpos", 8'h20, 32'd18);
      rd_chk("rms qneg", 8'h24, 32'h0);
      rd_chk("rms qsum", 8'h28, 32'd18);
      rd_chk("rms eneg", 8'h18, -32'sd20);
      rd_chk("rms epos", 8'h14, 32'h0);
      pulse(2);
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset_regs();
      t_manual_dc();
      t_standard();
      t_overflow();
      t_continuous();
      t_rms();
      end_of_test();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
